// ==== inc/i2cst_if.sv ====
/*
  Carrier between the top module and its SCL generator and address decoder.
  Assumes all members live in the i_clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface i2cst_if;
  logic        scl_s;
  logic        sda_s;
  logic        scl_rise;
  logic        start_p;
  logic        stop_p;
  logic        gen_en;
  logic        stop_req;
  logic [15:0] clk_cfg;
  logic        scl_low;
  logic        byte_done;
  logic [7:0]  rx_byte;
  modport top (output scl_s, sda_s, scl_rise, start_p, stop_p, gen_en,
               stop_req, clk_cfg, input scl_low, byte_done, rx_byte);
  modport gen (input gen_en, stop_req, clk_cfg, output scl_low);
  modport dec (input sda_s, scl_rise, start_p, stop_p,
               output byte_done, rx_byte);
endinterface
`default_nettype wire

// ==== inc/i2cst_pkg.sv ====
/*
  Constants for the I2C status and SCL timing block.
  Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
`default_nettype none
package i2cst_pkg;
  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_OWN  = 8'h04;
  localparam logic [7:0] ADR_ISTS = 8'h08;
  localparam logic [7:0] ADR_IMSK = 8'h0c;
  localparam logic [7:0] ADR_STS2 = 8'h18;
  localparam logic [7:0] ADR_CLK  = 8'h1c;
  localparam int unsigned ADR_LSB = 2;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CTL_EN = 0;
  localparam int unsigned CTL_START = 1;
  localparam int unsigned CTL_STOP = 2;
  localparam int unsigned CTL_PEC = 3;
  localparam int unsigned CTL_ARP = 4;
  localparam int unsigned CTL_HOST = 5;
  localparam int unsigned CTL_W = 7;
  localparam int unsigned OWN2_EN = 15;
  localparam int unsigned ST_MS = 0;
  localparam int unsigned ST_BUSY = 1;
  localparam int unsigned ST_TR = 2;
  localparam int unsigned ST_RSV = 3;
  localparam int unsigned ST_GC = 4;
  localparam int unsigned ST_DFLT = 5;
  localparam int unsigned ST_HOST = 6;
  localparam int unsigned ST_DUAL = 7;
  localparam int unsigned CLK_DUTY = 14;
  localparam int unsigned CLK_SPD = 15;
  localparam int unsigned IRQ_STOP = 0;
  localparam int unsigned IRQ_ADDR = 1;
  localparam int unsigned IRQ_ARB = 2;
  localparam int unsigned IRQ_W = 3;
  // ****************************************
  // Reset values, addresses, multipliers
  // ****************************************
  localparam logic [15:0] CLK_RST = 16'h0000;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [6:0] DFLT_ADDR = 7'h61;
  localparam logic [6:0] HOST_ADDR = 7'h08;
  localparam logic [4:0] MUL_ONE = 5'h01;
  localparam logic [4:0] MUL_FAST_LO = 5'h02;
  localparam logic [4:0] MUL_D9 = 5'h09;
  localparam logic [4:0] MUL_D16 = 5'h10;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [1:0] {
    I2CST_PH_HIGH = 2'b01,
    I2CST_PH_LOW  = 2'b10
  } i2cst_phase_t;
endpackage
`default_nettype wire

// ==== logic/i2cst_addrdec.sv ====
/*
  Collects the first byte after a start condition.
  Assumes synchronised SDA and a one-cycle SCL rising pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module i2cst_addrdec (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  i2cst_if.dec      bus
);
  logic       armed_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic       done_q;

  assign bus.byte_done = done_q;
  assign bus.rx_byte = sh_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      armed_q <= 1'b0;
      cnt_q   <= 3'h0;
      sh_q    <= 8'h00;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (bus.start_p)
      begin
        armed_q <= 1'b1;
        cnt_q   <= 3'h0;
      end
      else if (bus.stop_p)
        armed_q <= 1'b0;
      else if (armed_q && bus.scl_rise)
      begin
        sh_q  <= {sh_q[6:0], bus.sda_s};
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == i2cst_pkg::BIT_LAST)
        begin
          armed_q <= 1'b0;
          done_q  <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/i2cst_sclgen.sv ====
/*
  Master SCL high/low period generator.
  Assumes a configuration that only changes while generation is off.
*/
`timescale 1ns/1ns
`default_nettype none
module i2cst_sclgen (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  i2cst_if.gen      bus
);
  logic [11:0] setting;
  logic        fast;
  logic        duty;
  logic [4:0]  hi_m;
  logic [4:0]  lo_m;
  logic [16:0] hi_len;
  logic [16:0] lo_len;
  logic [16:0] len;
  logic        last;
  logic [16:0] cnt_q;
  i2cst_pkg::i2cst_phase_t ph_q;

  assign setting = bus.clk_cfg[11:0];
  assign fast = bus.clk_cfg[i2cst_pkg::CLK_SPD];
  assign duty = bus.clk_cfg[i2cst_pkg::CLK_DUTY];
  assign hi_m = (fast && duty) ? i2cst_pkg::MUL_D9 : i2cst_pkg::MUL_ONE;
  assign lo_m = !fast ? i2cst_pkg::MUL_ONE :
                duty ? i2cst_pkg::MUL_D16 : i2cst_pkg::MUL_FAST_LO;
  assign hi_len = {5'h00, setting} * {12'h000, hi_m};
  assign lo_len = {5'h00, setting} * {12'h000, lo_m};
  assign len = (ph_q == i2cst_pkg::I2CST_PH_LOW) ? lo_len : hi_len;
  // A zero setting still gives one cycle per phase
  assign last = (cnt_q + 17'h00001) >= len;
  assign bus.scl_low = (ph_q == i2cst_pkg::I2CST_PH_LOW);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || !bus.gen_en)
    begin
      cnt_q <= 17'h00000;
      ph_q  <= i2cst_pkg::I2CST_PH_HIGH;
    end
    else if (last)
    begin
      cnt_q <= 17'h00000;
      case (ph_q)
        // Stop request parks the line high
        i2cst_pkg::I2CST_PH_HIGH: ph_q <= bus.stop_req ? i2cst_pkg::I2CST_PH_HIGH
                                                       : i2cst_pkg::I2CST_PH_LOW;
        i2cst_pkg::I2CST_PH_LOW:  ph_q <= i2cst_pkg::I2CST_PH_HIGH;
        default:                  ph_q <= i2cst_pkg::I2CST_PH_HIGH;
      endcase
    end
    else
    begin
      cnt_q <= cnt_q + 17'h00001;
    end
  end
endmodule
`default_nettype wire

// ==== logic/i2cst_top.sv ====
/*
  I2C second status word and master SCL timing, with a Wishbone slave.
  Assumes the byte sequencer supplies arbitration loss and the running
  check byte on i_clk; SCL and SDA pins arrive asynchronously.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Role flag, status bit 0, is 1 while acting as master, else 0.
// - Role flag clears on stop, lost arbitration, or interface disabled.
// - Busy flag, status bit 1, sets whenever SDA or SCL is seen low.
// - Busy flag clears once a stop condition appears on the bus.
// - Direction flag, status bit 2, takes the address R/W bit as slave, its inverse as master; 1 transmits.
// - Direction flag clears on stop, repeated start, lost arbitration, disable.
// - Slave general call sets bit 4; stop, repeated start, disable clear it.
// - Slave default SMBus address sets bit 5 only with resolution enabled.
// - Slave host header sets bit 6 only with host select and resolution.
// - Bit 7 shows which own address matched: 0 first, 1 second.
// - Bits 15:8 show the running check byte when checking is enabled.
// - Standard or SMBus master: SCL high and low each setting clocks.
// - Fast, duty 0: high setting clocks, low twice that.
// - Fast, duty 1: high nine times, low sixteen times the setting.
// - Clock setup bit 15 selects fast speed, bit 14 the fast duty.
module i2cst_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_scl,
  output logic             o_scl,
  output logic             o_scl_oe,
  input  wire logic        i_sda,
  input  wire logic        i_arb_lost,
  input  wire logic [7:0]  i_pec_value,
  output logic             o_irq
);
  // ****************************************
  // Declarations
  // ****************************************
  i2cst_if bus ();

  logic [1:0]  scl_sync_q;
  logic [1:0]  sda_sync_q;
  logic        scl_prev_q;
  logic        sda_prev_q;
  logic        scl_s;
  logic        sda_s;

  logic [6:0]  ctrl_q;
  logic [15:0] own_q;
  logic [15:0] clk_q;
  logic [2:0]  imsk_q;
  logic [2:0]  ists_q;
  logic [2:0]  ists_d;
  logic [2:0]  w1c;
  logic [2:0]  ev;

  logic        ms_q;
  logic        busy_q;
  logic        tr_q;
  logic        gc_q;
  logic        dflt_q;
  logic        host_q;
  logic        dual_q;

  logic        ack_q;
  logic [31:0] dat_q;
  logic        scl_oe_q;
  logic        scl_q;
  logic        irq_q;

  logic        req;
  logic        wr;
  logic        wr_lo;
  logic        wr_hi;
  logic        hit_ctrl;
  logic        hit_own;
  logic        hit_ists;
  logic        hit_imsk;
  logic        hit_sts2;
  logic        hit_clk;
  logic [31:0] rd_word;
  logic [15:0] sts2;
  logic [15:0] ctrl_view;

  logic        en;
  logic        clr;
  logic        lost;
  logic [6:0]  addr7;
  logic        rw;
  logic        slave_byte;
  logic        m_first;
  logic        m_second;
  logic        m_gc;
  logic        m_dflt;
  logic        m_host;
  logic        addr_hit;

  // ****************************************
  // Pin sampling and line events
  // ****************************************
  // First stage is read by the second stage only
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign bus.scl_s = scl_s;
  assign bus.sda_s = sda_s;
  assign bus.scl_rise = scl_s & ~scl_prev_q;
  assign bus.start_p = sda_prev_q & ~sda_s & scl_s & scl_prev_q;
  assign bus.stop_p = ~sda_prev_q & sda_s & scl_s & scl_prev_q;

  // ****************************************
  // Submodules
  // ****************************************
  i2cst_sclgen u_sclgen (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .bus     (bus.gen)
  );

  i2cst_addrdec u_addrdec (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .bus     (bus.dec)
  );

  assign bus.gen_en = ms_q & en;
  assign bus.stop_req = ctrl_q[i2cst_pkg::CTL_STOP];
  assign bus.clk_cfg = clk_q;

  // ****************************************
  // Wishbone decode
  // ****************************************
  assign req = i_wb_cyc & i_wb_stb & ~ack_q;
  assign wr = req & i_wb_we;
  assign wr_lo = wr & i_wb_sel[0];
  assign wr_hi = wr & i_wb_sel[1];
  assign hit_ctrl = i_wb_adr[7:2] == i2cst_pkg::ADR_CTRL[7:2];
  assign hit_own = i_wb_adr[7:2] == i2cst_pkg::ADR_OWN[7:2];
  assign hit_ists = i_wb_adr[7:2] == i2cst_pkg::ADR_ISTS[7:2];
  assign hit_imsk = i_wb_adr[7:2] == i2cst_pkg::ADR_IMSK[7:2];
  assign hit_sts2 = i_wb_adr[7:2] == i2cst_pkg::ADR_STS2[7:2];
  assign hit_clk = i_wb_adr[7:2] == i2cst_pkg::ADR_CLK[7:2];

  assign ctrl_view = {9'h000, ctrl_q};
  // Status word has no write path at all
  assign rd_word = hit_ctrl ? {16'h0000, ctrl_view} :
                   hit_own  ? {16'h0000, own_q} :
                   hit_ists ? {29'h00000000, ists_q} :
                   hit_imsk ? {29'h00000000, imsk_q} :
                   hit_sts2 ? {16'h0000, sts2} :
                   hit_clk  ? {16'h0000, clk_q} :
                   32'h00000000;

  // ****************************************
  // Second status word
  // ****************************************
  assign sts2[i2cst_pkg::ST_MS] = ms_q;
  assign sts2[i2cst_pkg::ST_BUSY] = busy_q;
  assign sts2[i2cst_pkg::ST_TR] = tr_q;
  assign sts2[i2cst_pkg::ST_RSV] = 1'b0;
  assign sts2[i2cst_pkg::ST_GC] = gc_q;
  assign sts2[i2cst_pkg::ST_DFLT] = dflt_q;
  assign sts2[i2cst_pkg::ST_HOST] = host_q;
  assign sts2[i2cst_pkg::ST_DUAL] = dual_q;
  // Byte is live, not latched, so reads track the sequencer
  assign sts2[15:8] = ctrl_q[i2cst_pkg::CTL_PEC] ? i_pec_value : 8'h00;

  // ****************************************
  // Address byte matching
  // ****************************************
  assign en = ctrl_q[i2cst_pkg::CTL_EN];
  assign lost = i_arb_lost & ms_q;
  // Every start clears; a first start finds the flags clear anyway
  assign clr = bus.stop_p | bus.start_p | ~en;
  assign addr7 = bus.rx_byte[7:1];
  assign rw = bus.rx_byte[0];
  assign slave_byte = bus.byte_done & ~ms_q & en;
  assign m_first = addr7 == own_q[6:0];
  assign m_second = own_q[i2cst_pkg::OWN2_EN] & (addr7 == own_q[14:8]);
  assign m_gc = addr7 == i2cst_pkg::GC_ADDR;
  assign m_dflt = (addr7 == i2cst_pkg::DFLT_ADDR) & ctrl_q[i2cst_pkg::CTL_ARP];
  assign m_host = (addr7 == i2cst_pkg::HOST_ADDR) & ctrl_q[i2cst_pkg::CTL_ARP] &
                  ctrl_q[i2cst_pkg::CTL_HOST];
  assign addr_hit = slave_byte & (m_first | m_second | m_gc | m_dflt | m_host);

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ctrl_q <= i2cst_pkg::CTRL_RST;
      own_q  <= 16'h0000;
      clk_q  <= i2cst_pkg::CLK_RST;
      imsk_q <= 3'h0;
    end
    else
    begin
      ctrl_q[i2cst_pkg::CTL_START] <= 1'b0;
      if (bus.stop_p || !en)
        ctrl_q[i2cst_pkg::CTL_STOP] <= 1'b0;
      if (wr_lo && hit_ctrl)
        ctrl_q <= i_wb_dat[6:0];
      if (wr_lo && hit_own)
        own_q[7:0] <= i_wb_dat[7:0];
      if (wr_hi && hit_own)
        own_q[15:8] <= i_wb_dat[15:8];
      if (wr_lo && hit_clk)
        clk_q[7:0] <= i_wb_dat[7:0];
      if (wr_hi && hit_clk)
        clk_q[15:8] <= i_wb_dat[15:8];
      if (wr_lo && hit_imsk)
        imsk_q <= i_wb_dat[2:0];
    end
  end

  // ****************************************
  // Role, busy and direction flags
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ms_q   <= 1'b0;
      busy_q <= 1'b0;
      tr_q   <= 1'b0;
    end
    else
    begin
      if (!en || bus.stop_p || lost)
        ms_q <= 1'b0;
      else if (ctrl_q[i2cst_pkg::CTL_START])
        ms_q <= 1'b1;

      if (!sda_s || !scl_s)
        busy_q <= 1'b1;
      else if (bus.stop_p)
        busy_q <= 1'b0;

      if (bus.byte_done && en)
        tr_q <= ms_q ? ~rw : rw;
      else if (clr || lost)
        tr_q <= 1'b0;
    end
  end

  // ****************************************
  // Slave address flags
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      gc_q   <= 1'b0;
      dflt_q <= 1'b0;
      host_q <= 1'b0;
      dual_q <= 1'b0;
    end
    else if (slave_byte)
    begin
      if (m_gc)
        gc_q <= 1'b1;
      if (m_dflt)
        dflt_q <= 1'b1;
      if (m_host)
        host_q <= 1'b1;
      if (m_first || m_second)
        dual_q <= ~m_first;
    end
    else if (clr)
    begin
      gc_q   <= 1'b0;
      dflt_q <= 1'b0;
      host_q <= 1'b0;
      dual_q <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  assign ev[i2cst_pkg::IRQ_STOP] = bus.stop_p;
  assign ev[i2cst_pkg::IRQ_ADDR] = addr_hit;
  assign ev[i2cst_pkg::IRQ_ARB] = lost;
  assign w1c = (wr_lo && hit_ists) ? i_wb_dat[2:0] : 3'h0;
  // New event wins over a clear in the same cycle
  assign ists_d = (ists_q & ~w1c) | ev;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ists_q <= 3'h0;
      irq_q  <= 1'b0;
    end
    else
    begin
      ists_q <= ists_d;
      irq_q  <= |(ists_d & imsk_q);
    end
  end

  // ****************************************
  // Bus answer and pin drive
  // ****************************************
  // One wait state; unmapped addresses answer with zero
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ack_q    <= 1'b0;
      dat_q    <= 32'h00000000;
      scl_oe_q <= 1'b0;
      scl_q    <= 1'b0;
    end
    else
    begin
      ack_q    <= req;
      dat_q    <= req ? rd_word : 32'h00000000;
      scl_oe_q <= bus.scl_low;
      scl_q    <= 1'b0;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = dat_q;
  assign o_scl_oe = scl_oe_q;
  assign o_scl = scl_q;
  assign o_irq = irq_q;
endmodule
`default_nettype wire

// ==== verif/i2cst_partner.sv ====
/*
  Behavioural far-side I2C device: frames start, address byte and stop.
  Assumes open-drain lines with pull-ups; a pull output high drives low.
*/
`timescale 1ns/1ns
`default_nettype none
module i2cst_partner (
  output logic o_sda_pull,
  output logic o_scl_pull
);
  // ****************************************
  // Frame tasks, 400 ns link clock
  // ****************************************
  initial
  begin
    o_sda_pull = 1'b0;
    o_scl_pull = 1'b0;
  end
  // Works from idle or mid-frame, so it also makes a repeated start
  task automatic start_cond();
    // Callers return on a clock edge; the offset keeps pin changes off it
    #10;
    o_sda_pull = 1'b0;
    #100 o_scl_pull = 1'b0;
    #100 o_sda_pull = 1'b1;
    #200 o_scl_pull = 1'b1;
  endtask
  // Leaves SCL held low, so the link clock stands still between frames
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      o_sda_pull = !b[i];
      #100 o_scl_pull = 1'b0;
      #200 o_scl_pull = 1'b1;
      #100;
    end
  endtask
  task automatic stop_cond();
    #10;
    o_sda_pull = 1'b1;
    #100 o_scl_pull = 1'b0;
    #200 o_sda_pull = 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

// ==== verif/i2cst_top_bench.sv ====
/*
  Self-checking bench: Wishbone tasks, SCL timing and slave flag tests.
  Assumes the partner model on the pins and the bound port checker.
*/
`timescale 1ns/1ns
`default_nettype none
module i2cst_top_bench;
  localparam logic [15:0] MODE [0:3] = '{16'h0003, 16'h4001, 16'h8002, 16'hc001};
  localparam int          HI   [0:3] = '{3, 1, 2, 9};
  localparam int          LO   [0:3] = '{3, 1, 4, 16};
  localparam logic [7:0]  SCTL [0:6] = '{8'h39, 8'h39, 8'h39, 8'h29, 8'h11, 8'h39, 8'h39};
  localparam logic [7:0]  SBYT [0:6] = '{8'h00, 8'hc2, 8'h10, 8'hc2, 8'h10, 8'h55, 8'h6b};
  localparam logic [7:0]  SEXP [0:6] = '{8'h12, 8'h22, 8'h42, 8'h02, 8'h02, 8'h06, 8'h86};
  logic        clk = 1'b0;
  logic        rst_n, cyc, stb, we, arb, ack, scl_o, scl_oe, irq;
  logic [7:0]  adr, pec;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  int          n_mismatch = 0;
  int          checks = 0;
  int          hi, lo;
  wire logic   sda_pull, scl_pull, scl_w, sda_w;
  // Pull-ups: a released line reads high
  assign scl_w = !(scl_pull || (scl_oe && !scl_o));
  assign sda_w = !sda_pull;
  i2cst_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_scl(scl_w), .o_scl(scl_o), .o_scl_oe(scl_oe), .i_sda(sda_w), .i_arb_lost(arb),
    .i_pec_value(pec), .o_irq(irq));
  i2cst_partner dev (.o_sda_pull(sda_pull), .o_scl_pull(scl_pull));
  always #25 clk = !clk;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
      n_mismatch++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, q & m, e);
  endtask
  // Counts one whole released (high) phase and the following driven phase
  task automatic meas();
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    while (scl_oe !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    while (scl_oe === 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    while (scl_oe === 1'b0 && n < 200)
    begin
      @(posedge clk);
      hi++;
      n++;
    end
    while (scl_oe === 1'b1 && n < 200)
    begin
      @(posedge clk);
      lo++;
      n++;
    end
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    {rst_n, cyc, stb, we, arb} = 5'h00;
    {adr, pec} = 16'h0000;
    sel = 4'hf;
    wdat = 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(i2cst_pkg::ADR_STS2, 32'hffffffff, 32'h0, "status two reset");
    rd(i2cst_pkg::ADR_CLK, 32'hffffffff, 32'h0, "clock setup reset");
    wb(1'b1, i2cst_pkg::ADR_STS2, 32'hffffffff);
    rd(i2cst_pkg::ADR_STS2, 32'hffffffff, 32'h0, "status two write");
    wb(1'b1, 8'h30, 32'hffffffff);
    rd(8'h30, 32'hffffffff, 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, i2cst_pkg::ADR_CLK, {16'h0, MODE[i]});
      rd(i2cst_pkg::ADR_CLK, 32'hffffffff, {16'h0, MODE[i]}, "clock setup");
      wb(1'b1, i2cst_pkg::ADR_CTRL, 32'h3);
      meas();
      chk("scl high cycles", hi, HI[i]);
      chk("scl low cycles", lo, LO[i]);
      rd(i2cst_pkg::ADR_STS2, 32'hffff, 32'h3, "master status");
      wb(1'b1, i2cst_pkg::ADR_CTRL, 32'h0);
      rd(i2cst_pkg::ADR_STS2, 32'h5, 32'h0, "role after disable");
    end
    // Stop request must park SCL released after the high phase
    wb(1'b1, i2cst_pkg::ADR_CTRL, 32'h7);
    hi = 0;
    repeat (30)
    begin
      @(posedge clk);
      hi = hi + int'(scl_oe);
    end
    chk("scl parked by stop request", hi, 32'h0);
    rd(i2cst_pkg::ADR_STS2, 32'h1, 32'h1, "role while parked");
    wb(1'b1, i2cst_pkg::ADR_IMSK, 32'h4);
    wb(1'b1, i2cst_pkg::ADR_CTRL, 32'h3);
    repeat (10) @(posedge clk);
    arb <= 1'b1;
    @(posedge clk);
    arb <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq on arbitration loss", irq, 32'h1);
    rd(i2cst_pkg::ADR_STS2, 32'h1, 32'h0, "role after arbitration loss");
    wb(1'b1, i2cst_pkg::ADR_ISTS, 32'h4);
    chk("irq after clear", irq, 32'h0);
    wb(1'b1, i2cst_pkg::ADR_CTRL, 32'h0);
    wb(1'b1, i2cst_pkg::ADR_IMSK, 32'h0);
    wb(1'b1, i2cst_pkg::ADR_OWN, 32'h0000b52a);
    for (int i = 0; i < 7; i++)
    begin
      wb(1'b1, i2cst_pkg::ADR_CTRL, {24'h0, SCTL[i]});
      pec <= 8'h50 + 8'(i);
      dev.start_cond();
      dev.send_byte(SBYT[i]);
      @(posedge clk);
      rd(i2cst_pkg::ADR_STS2, 32'hffff, {16'h0, SCTL[i][3] ? pec : 8'h00, SEXP[i]}, "slave flags");
      if (i == 6)
      begin
        dev.start_cond();
        @(posedge clk);
        rd(i2cst_pkg::ADR_STS2, 32'hff, 32'h2, "after repeated start");
      end
      dev.stop_cond();
      @(posedge clk);
      rd(i2cst_pkg::ADR_STS2, 32'hff, 32'h0, "after stop");
    end
    chk("stop event masked", irq, 32'h0);
    wb(1'b1, i2cst_pkg::ADR_IMSK, 32'h1);
    chk("stop event unmasked", irq, 32'h1);
    wb(1'b1, i2cst_pkg::ADR_ISTS, 32'hf);
    chk("irq after clear all", irq, 32'h0);
    give_verdict();
  end
  initial
  begin
    #500000;
    n_mismatch++;
    give_verdict();
  end
endmodule
bind i2cst_top i2cst_top_properties u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_arb_lost(i_arb_lost), .o_irq(o_irq));
`default_nettype wire

// ==== verif/i2cst_top_properties.sv ====
/*
  Port checks for the status and SCL timing block.
  Assumes a bind to i2cst_top; everything is in the i_clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module i2cst_top_properties (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_scl,
  input wire logic        o_scl,
  input wire logic        o_scl_oe,
  input wire logic        i_arb_lost,
  input wire logic        o_irq
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic sts2_rd;
  assign sts2_rd = o_wb_ack && !i_wb_we && (i_wb_adr == i2cst_pkg::ADR_STS2);
  a_ack_one_beat: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held over one cycle");
  a_ack_answers_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered next cycle");
  a_ack_has_req: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data not zero outside ack");
  a_status_spare_zero: assert property (sts2_rd |-> o_wb_dat[31:16] == 16'h0 && !o_wb_dat[3])
    else $error("status two spare bits not zero");
  a_quiet_after_reset: assert property ($rose(i_rst_n) |-> !o_wb_ack && !o_irq && !o_scl_oe)
    else $error("outputs active after reset");
  a_scl_only_low: assert property (o_scl == 1'b0)
    else $error("SCL driven high");
  a_busy_on_low: assert property (sts2_rd && !$past(i_scl, 4) && !$past(i_scl, 5) && !$past(i_scl, 6) |-> o_wb_dat[1])
    else $error("busy flag clear while SCL low");
  a_arb_stops_scl: assert property (i_arb_lost |-> ##[1:3] !o_scl_oe)
    else $error("SCL still driven after arbitration loss");
endmodule
`default_nettype wire
